// >>> rtl/acrb_bank.sv
`timescale 1ns/1ns
`include "acrb_cfg.svh"

module acrb_bank
    import acrb_pkg::*;
#(
    // arbitrary neutral value
    parameter logic [15:0] FAMILY_ID = 16'h5A3C
)
(
    input  wire logic         ref_clk,
    input  wire logic         arst_n,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         lineZeroCrossing,
    input  wire logic         spkZeroCrossing,
    output acrb_gain_t        lineCfg,
    output acrb_gain_t        spkCfg,
    output logic [5:0]        lineVolume,
    output logic [5:0]        spkVolume,
    output acrb_midref_t      midRef,
    output acrb_bias_t        bias,
    output logic [2:0]        biasQuarters,
    output acrb_path_t        path
);

    // =================================================================
    // word packing helpers
    function automatic logic [15:0] merge16
    (
        input logic [15:0] oldWord,
        input logic [15:0] newWord,
        input logic [1:0]  strb
    );
        merge16 = oldWord;
        if (strb[0])
        begin
            merge16[7:0] = newWord[7:0];
        end
        if (strb[1])
        begin
            merge16[15:8] = newWord[15:8];
        end
    endfunction

    function automatic logic [15:0] midref_word(input acrb_midref_t m);
        midref_word = 16'h0000;
        midref_word[`ACRB_MR_BUF_BIT] = m.bufferOn;
        midref_word[`ACRB_MR_SOFT_BIT] = m.softStart;
        midref_word[`ACRB_MR_DIV_LSB +: 2] = m.dividerSelect;
        midref_word[`ACRB_MR_SLEW_BIT] = m.slewFast;
    endfunction

    function automatic acrb_midref_t midref_field(input logic [15:0] w);
        midref_field.bufferOn = w[`ACRB_MR_BUF_BIT];
        midref_field.softStart = w[`ACRB_MR_SOFT_BIT];
        midref_field.dividerSelect = w[`ACRB_MR_DIV_LSB +: 2];
        midref_field.slewFast = w[`ACRB_MR_SLEW_BIT];
    endfunction

    // standby level wins over master level when selected
    function automatic logic [2:0] bias_quarters(input acrb_bias_t b);
        if (b.standbySelect)
        begin
            bias_quarters = b.standbyLevel ? `ACRB_Q_X025 : `ACRB_Q_X050;
        end
        else
        begin
            unique case (b.masterLevel)
                2'b00: bias_quarters = `ACRB_Q_X050;
                2'b01: bias_quarters = `ACRB_Q_X075;
                2'b10: bias_quarters = `ACRB_Q_X100;
                2'b11: bias_quarters = `ACRB_Q_X150;
            endcase
        end
    endfunction

    // =================================================================
    // bus decode
    acrb_state_t stateQ;
    acrb_state_t stateD;
    logic [5:0]  regIndex;
    logic        addrMapped;
    logic        setupPhase;
    logic        writeTaken;
    logic        softReset;
    logic [15:0] readWord;

    assign regIndex = paddr[7:2];
    assign setupPhase = psel && !penable && !stateQ.pready;
    assign writeTaken = psel && penable && stateQ.pready && pwrite && addrMapped;
    assign softReset = writeTaken && (regIndex == `ACRB_IDX_SOFT_RESET_IDENT);

    always_comb
    begin
        addrMapped = (paddr[1:0] == 2'b00);
        readWord = 16'h0000;
        unique case (regIndex)
            `ACRB_IDX_SOFT_RESET_IDENT:
                readWord = FAMILY_ID;
            `ACRB_IDX_LINE_OUTPUT_LEVEL:
                readWord = {8'h00, stateQ.lineCfg};
            `ACRB_IDX_SPEAKER_GAIN_LEVEL:
                readWord = {8'h00, stateQ.spkCfg};
            `ACRB_IDX_MID_REFERENCE_CTRL:
                readWord = midref_word(stateQ.midRef);
            `ACRB_IDX_BIAS_CONTROL:
                readWord = {9'h000, stateQ.bias};
            `ACRB_IDX_ANALOGUE_PATH_SEL:
                readWord = {11'h000, stateQ.path};
            default:
                addrMapped = 1'b0;
        endcase
    end

    // =================================================================
    // next state
    always_comb
    begin
        stateD = stateQ;
        stateD.pready = 1'b0;
        stateD.pslverr = 1'b0;

        // one wait-free access cycle; read data latched in setup, write data taken in access
        if (setupPhase)
        begin
            stateD.pready = 1'b1;
            stateD.pslverr = !addrMapped;
            stateD.prdata = (pwrite || !addrMapped) ? 32'h0000_0000 : {16'h0000, readWord};
        end

        // volume follows at once or waits for a crossing
        if (!stateQ.lineCfg.zeroCross || lineZeroCrossing)
        begin
            stateD.lineVol = stateQ.lineCfg.volume;
        end
        if (!stateQ.spkCfg.zeroCross || spkZeroCrossing)
        begin
            stateD.spkVol = stateQ.spkCfg.volume;
        end
        stateD.biasQuarters = bias_quarters(stateQ.bias);

        if (writeTaken)
        begin
            unique case (regIndex)
                `ACRB_IDX_LINE_OUTPUT_LEVEL:
                    stateD.lineCfg = acrb_gain_t'(8'(merge16({8'h00, stateQ.lineCfg},
                        pwdata[15:0], pstrb[1:0])));
                `ACRB_IDX_SPEAKER_GAIN_LEVEL:
                    stateD.spkCfg = acrb_gain_t'(8'(merge16({8'h00, stateQ.spkCfg},
                        pwdata[15:0], pstrb[1:0])));
                `ACRB_IDX_MID_REFERENCE_CTRL:
                    stateD.midRef = midref_field(merge16(midref_word(stateQ.midRef),
                        pwdata[15:0], pstrb[1:0]));
                `ACRB_IDX_BIAS_CONTROL:
                    stateD.bias = acrb_bias_t'(7'(merge16({9'h000, stateQ.bias},
                        pwdata[15:0], pstrb[1:0])));
                `ACRB_IDX_ANALOGUE_PATH_SEL:
                    stateD.path = acrb_path_t'(5'(merge16({11'h000, stateQ.path},
                        pwdata[15:0], pstrb[1:0])));
                default:
                    stateD.path = stateQ.path;
            endcase
        end

        // data word and strobes do not matter here
        if (softReset)
        begin
            stateD.lineCfg = `ACRB_RST_GAIN;
            stateD.spkCfg = `ACRB_RST_GAIN;
            stateD.midRef = `ACRB_RST_MIDREF;
            stateD.bias = `ACRB_RST_BIAS;
            stateD.path = `ACRB_RST_PATH;
            stateD.lineVol = `ACRB_RST_VOLUME;
            stateD.spkVol = `ACRB_RST_VOLUME;
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateQ.lineCfg <= `ACRB_RST_GAIN;
            stateQ.spkCfg <= `ACRB_RST_GAIN;
            stateQ.midRef <= `ACRB_RST_MIDREF;
            stateQ.bias <= `ACRB_RST_BIAS;
            stateQ.path <= `ACRB_RST_PATH;
            stateQ.lineVol <= `ACRB_RST_VOLUME;
            stateQ.spkVol <= `ACRB_RST_VOLUME;
            stateQ.biasQuarters <= `ACRB_Q_X100;
            stateQ.pready <= 1'b0;
            stateQ.pslverr <= 1'b0;
            stateQ.prdata <= 32'h0000_0000;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

    // =================================================================
    // outputs
    assign prdata = stateQ.prdata;
    assign pready = stateQ.pready;
    assign pslverr = stateQ.pslverr;
    assign lineCfg = stateQ.lineCfg;
    assign spkCfg = stateQ.spkCfg;
    assign lineVolume = stateQ.lineVol;
    assign spkVolume = stateQ.spkVol;
    assign midRef = stateQ.midRef;
    assign bias = stateQ.bias;
    assign biasQuarters = stateQ.biasQuarters;
    assign path = stateQ.path;

    // =================================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    sequence sSetup;
        setupPhase;
    endsequence

    sequence sAccessDone;
        pready && psel && penable;
    endsequence

    sequence sWriteIdx(logic [5:0] idx);
        writeTaken && regIndex == idx;
    endsequence

    sequence sSoftReset;
        softReset;
    endsequence

    chk_answer_one_cycle: assert property (
        sSetup |=> sAccessDone ##1 !pready)
        else $error("access phase not answered in one cycle");

    chk_soft_reset_all: assert property (
        sWriteIdx(`ACRB_IDX_SOFT_RESET_IDENT) |=>
            lineCfg == `ACRB_RST_GAIN && spkCfg == `ACRB_RST_GAIN
            && midRef == `ACRB_RST_MIDREF && bias == `ACRB_RST_BIAS
            && path == `ACRB_RST_PATH)
        else $error("soft reset left a register off default");

    chk_ident_read: assert property (
        sSetup and (!pwrite && paddr == 8'h00) |=>
            prdata == {16'h0000, FAMILY_ID} && !pslverr)
        else $error("offset zero did not read the family code");

    chk_line_default: assert property (
        sWriteIdx(`ACRB_IDX_SOFT_RESET_IDENT) |=>
            lineCfg.volume == 6'h39 && lineCfg.mute ##1 lineVolume == 6'h39)
        else $error("line output default wrong");

    chk_spk_default: assert property (
        sWriteIdx(`ACRB_IDX_SOFT_RESET_IDENT) |=>
            spkCfg.volume == 6'h39 && spkCfg.mute && !spkCfg.zeroCross)
        else $error("speaker gain default wrong");

    chk_line_immediate: assert property (
        !lineCfg.zeroCross && !softReset |=> lineVolume == $past(lineCfg.volume))
        else $error("line volume not applied at once");

    chk_spk_zc_hold: assert property (
        spkCfg.zeroCross && !spkZeroCrossing && !softReset |=> $stable(spkVolume))
        else $error("speaker volume changed without a crossing");

    chk_spk_zc_apply: assert property (
        spkCfg.zeroCross && spkZeroCrossing && !softReset
            |=> spkVolume == $past(spkCfg.volume))
        else $error("speaker volume missed the crossing");

    chk_midref_write: assert property (
        sWriteIdx(`ACRB_IDX_MID_REFERENCE_CTRL) and pstrb[0] |=>
            midRef.bufferOn == $past(pwdata[5]) && midRef.softStart == $past(pwdata[3])
            && midRef.dividerSelect == $past(pwdata[2:1])
            && midRef.slewFast == $past(pwdata[0]))
        else $error("mid reference fields not stored");

    chk_bias_write: assert property (
        sWriteIdx(`ACRB_IDX_BIAS_CONTROL) and pstrb[0] |=>
            bias == $past(pwdata[6:0]))
        else $error("bias fields not stored");

    // level is judged on the field seen one cycle earlier; a write may follow at once
    chk_bias_level_pick: assert property (
        bias.standbySelect |=>
            biasQuarters == ($past(bias.standbyLevel) ? `ACRB_Q_X025 : `ACRB_Q_X050))
        else $error("standby level not applied");

    chk_master_level: assert property (
        !bias.standbySelect && bias.masterLevel == 2'b11 |=> biasQuarters == 3'h6)
        else $error("master level x1.5 not applied");

    chk_unmapped_zero: assert property (
        sSetup and (!pwrite && paddr == 8'h04) |=> prdata == 32'h0 && pslverr)
        else $error("unmapped read not zero with error");

    chk_reserved_zero: assert property (
        sSetup and (!pwrite && paddr == 8'h10) |=> prdata[31:6] == 26'h0
            && prdata[4] == 1'b0)
        else $error("reserved mid reference bits read nonzero");

    chk_line_zc_hold: assert property (
        lineCfg.zeroCross && !lineZeroCrossing && !softReset |=> $stable(lineVolume))
        else $error("line volume changed without a crossing");

    chk_line_zc_apply: assert property (
        lineCfg.zeroCross && lineZeroCrossing && !softReset
            |=> lineVolume == $past(lineCfg.volume))
        else $error("line volume missed the crossing");

    chk_spk_immediate: assert property (
        !spkCfg.zeroCross && !softReset |=> spkVolume == $past(spkCfg.volume))
        else $error("speaker volume not applied at once");

    chk_buffer_default: assert property (
        sSoftReset |=> !midRef.bufferOn)
        else $error("reference buffer not off after soft reset");

    chk_soft_start_off: assert property (
        sSoftReset |=> !midRef.softStart)
        else $error("soft start not off after soft reset");

    chk_divider_default: assert property (
        sSoftReset |=> midRef.dividerSelect == 2'b00)
        else $error("divider select not off after soft reset");

    chk_slew_default: assert property (
        sSoftReset |=> midRef.slewFast)
        else $error("slew rate not fast after soft reset");

    chk_source_default: assert property (
        sSoftReset |=> bias.sourceSelect)
        else $error("bias source not start-up after soft reset");

    chk_standby_default: assert property (
        sSoftReset |=> bias.standbyLevel && !bias.standbySelect)
        else $error("standby bias fields off default");

    chk_normal_off: assert property (
        sSoftReset |=> !bias.normalOn)
        else $error("normal bias generator on after soft reset");

    chk_startup_off: assert property (
        sSoftReset |=> !bias.startupOn)
        else $error("start-up bias generator on after soft reset");

    chk_master_default: assert property (
        sSoftReset |=> bias.masterLevel == 2'b10 ##1 biasQuarters == `ACRB_Q_X100)
        else $error("master bias default not normal");

    chk_master_half: assert property (
        !bias.standbySelect && bias.masterLevel == 2'b00 |=> biasQuarters == `ACRB_Q_X050)
        else $error("master level x0.5 not applied");

    chk_master_three: assert property (
        !bias.standbySelect && bias.masterLevel == 2'b01 |=> biasQuarters == `ACRB_Q_X075)
        else $error("master level x0.75 not applied");

    chk_misaligned_error: assert property (
        sSetup and (paddr[1:0] != 2'b00) |=> pslverr && prdata == 32'h0000_0000)
        else $error("misaligned access not refused");

    chk_ignored_write: assert property (
        sAccessDone and (pwrite && !addrMapped) |=> $stable(lineCfg) && $stable(spkCfg)
            && $stable(midRef) && $stable(bias) && $stable(path))
        else $error("refused write changed a register");

    chk_ready_after_setup: assert property (
        pready |-> $past(setupPhase))
        else $error("ready without a setup cycle");

endmodule

// >>> rtl/acrb_cfg.svh
// Behaviour
// - any write to offset zero restores defaults
// - offset zero reads fixed family identification code
// - line volume six-bit, 0dB reset, muted
// - speaker gain same coding, muted, zc off
// - zero-cross bit defers volume until crossing
// - bit 5 enables buffered mid-rail reference
// - bit 3 selects reference soft start
// - bits 2:1 select reference divider, reset off
// - bit 0 selects fast reference slew
// - bit 6 selects start-up bias source
// - bit 5 selects standby bias level
// - bit 4 picks standby or master level
// - bits 3:2 master bias multiplier, reset normal
// - bit 1 enables normal bias generator
// - bit 0 enables start-up bias generator
`ifndef ACRB_CFG_SVH
`define ACRB_CFG_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define ACRB_IDX_SOFT_RESET_IDENT   6'h00
`define ACRB_IDX_LINE_OUTPUT_LEVEL  6'h02
`define ACRB_IDX_SPEAKER_GAIN_LEVEL 6'h03
`define ACRB_IDX_MID_REFERENCE_CTRL 6'h04
`define ACRB_IDX_BIAS_CONTROL       6'h05
`define ACRB_IDX_ANALOGUE_PATH_SEL  6'h07

// =====================================================================
// reset values, register-word form
`define ACRB_RST_GAIN     8'hB9
`define ACRB_RST_MIDREF   5'h01
`define ACRB_RST_BIAS     7'h68
`define ACRB_RST_PATH     5'h00
`define ACRB_RST_VOLUME   6'h39

// =====================================================================
// mid-reference field positions
`define ACRB_MR_BUF_BIT   5
`define ACRB_MR_SOFT_BIT  3
`define ACRB_MR_DIV_LSB   1
`define ACRB_MR_SLEW_BIT  0

// =====================================================================
// bias current in quarters of normal
`define ACRB_Q_X025  3'h1
`define ACRB_Q_X050  3'h2
`define ACRB_Q_X075  3'h3
`define ACRB_Q_X100  3'h4
`define ACRB_Q_X150  3'h6

`endif

// >>> rtl/acrb_pkg.sv
package acrb_pkg;

    typedef struct packed {
        logic       mute;
        logic       zeroCross;
        logic [5:0] volume;
    } acrb_gain_t;

    typedef struct packed {
        logic       bufferOn;
        logic       softStart;
        logic [1:0] dividerSelect;
        logic       slewFast;
    } acrb_midref_t;

    typedef struct packed {
        logic       sourceSelect;
        logic       standbyLevel;
        logic       standbySelect;
        logic [1:0] masterLevel;
        logic       normalOn;
        logic       startupOn;
    } acrb_bias_t;

    typedef struct packed {
        logic dacSel;
        logic in2Vol;
        logic in2Ena;
        logic in1Vol;
        logic in1Ena;
    } acrb_path_t;

    typedef struct packed {
        acrb_gain_t   lineCfg;
        acrb_gain_t   spkCfg;
        acrb_midref_t midRef;
        acrb_bias_t   bias;
        acrb_path_t   path;
        logic [5:0]   lineVol;
        logic [5:0]   spkVol;
        logic [2:0]   biasQuarters;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
    } acrb_state_t;

endpackage

// >>> tb/acrb_bank_tb.sv
`timescale 1ns/1ns

module acrb_bank_tb;
    import acrb_pkg::*;

    // arbitrary identification value
    localparam logic [15:0] FAM_ID = 16'hC3A5;

    logic         ref_clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [3:0]   pstrb = 4'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         lineZc = 1'b0;
    logic         spkZc = 1'b0;
    acrb_gain_t   lineCfg;
    acrb_gain_t   spkCfg;
    logic [5:0]   lineVolume;
    logic [5:0]   spkVolume;
    acrb_midref_t midRef;
    acrb_bias_t   bias;
    logic [2:0]   biasQuarters;
    acrb_path_t   path;
    int           bad_count = 0;
    int           cmp_count = 0;
    logic [31:0]  rdat;
    logic         err;
    logic [5:0]   idxTab [5] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h07};
    logic [15:0]  maskTab [5] = '{16'h00FF, 16'h00FF, 16'h002F, 16'h007F, 16'h001F};
    logic [15:0]  biasTab [7] = '{16'h00, 16'h04, 16'h08, 16'h0C, 16'h30, 16'h10, 16'h3C};
    logic [2:0]   quartTab [7] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h1, 3'h2, 3'h1};
    logic [5:0]   volTab [4] = '{6'h00, 6'h01, 6'h39, 6'h3F};

    acrb_bank #(.FAMILY_ID(FAM_ID)) uut (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lineZeroCrossing(lineZc), .spkZeroCrossing(spkZc),
        .lineCfg(lineCfg), .spkCfg(spkCfg), .lineVolume(lineVolume),
        .spkVolume(spkVolume), .midRef(midRef), .bias(bias),
        .biasQuarters(biasQuarters), .path(path)
    );

    always #25 ref_clk = ~ref_clk;

    // ==========
    // checking and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic xfer(input logic [5:0] idx, input logic [1:0] low, input logic wr,
                        input logic [15:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, low};
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wrReg(input logic [5:0] idx, input logic [15:0] d);
        xfer(idx, 2'b00, 1'b1, d, 4'hF);
    endtask

    task automatic rdReg(input logic [5:0] idx, input logic [15:0] exp);
        xfer(idx, 2'b00, 1'b0, 16'h0000, 4'h0);
        chk(rdat, {16'h0000, exp}, "read data");
        chk(32'(err), 32'h0, "read error");
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========
    // watchdog
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        $display("MISMATCH at %0t: run timed out", $time);
        conclude();
    end

    // ==========
    // tests
    initial
    begin
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdReg(6'h00, FAM_ID);
        rdReg(6'h02, 16'h00B9);
        rdReg(6'h03, 16'h00B9);
        rdReg(6'h04, 16'h0001);
        rdReg(6'h05, 16'h0068);
        rdReg(6'h07, 16'h0000);
        chk(32'(lineVolume), 32'h39, "line volume");
        chk(32'(biasQuarters), 32'h4, "bias quarters");
        $display("test defaults done");

        for (int i = 0; i < 5; i++)
        begin
            wrReg(idxTab[i], 16'hFFFF);
            rdReg(idxTab[i], maskTab[i]);
        end
        tick(1);
        chk(32'(midRef), 32'h1F, "mid reference ones");
        chk(32'(bias), 32'h7F, "bias ones");
        chk(32'(lineCfg), 32'hFF, "line config ones");
        chk(32'(spkCfg), 32'hFF, "speaker config ones");
        chk(32'(path), 32'h1F, "path ones");
        for (int i = 0; i < 5; i++)
        begin
            wrReg(idxTab[i], 16'h0000);
            rdReg(idxTab[i], 16'h0000);
        end
        $display("test fields done");

        foreach (volTab[i])
        begin
            wrReg(6'h02, {10'h000, volTab[i]});
            wrReg(6'h03, {8'h00, 2'b10, volTab[i]});
            tick(2);
            chk(32'(lineVolume), 32'(volTab[i]), "line volume");
            chk(32'(spkVolume), 32'(volTab[i]), "speaker volume");
            chk(32'(spkCfg.mute), 32'h1, "speaker mute");
        end
        wrReg(6'h02, 16'h0039);
        wrReg(6'h03, 16'h0039);
        wrReg(6'h02, 16'h0050);
        wrReg(6'h03, 16'h0045);
        tick(3);
        chk(32'(lineVolume), 32'h39, "line held");
        chk(32'(spkVolume), 32'h39, "speaker held");
        @(posedge ref_clk);
        lineZc <= 1'b1;
        @(posedge ref_clk);
        lineZc <= 1'b0;
        #1;
        chk(32'(lineVolume), 32'h10, "line at crossing");
        chk(32'(spkVolume), 32'h39, "speaker waits");
        @(posedge ref_clk);
        spkZc <= 1'b1;
        @(posedge ref_clk);
        spkZc <= 1'b0;
        #1;
        chk(32'(spkVolume), 32'h05, "speaker at crossing");
        $display("test volume done");

        for (int k = 0; k < 4; k++)
        begin
            wrReg(6'h04, 16'(k << 1));
            tick(1);
            chk(32'(midRef.dividerSelect), 32'(k), "divider select");
        end
        foreach (biasTab[i])
        begin
            wrReg(6'h05, biasTab[i]);
            tick(2);
            chk(32'(biasQuarters), 32'(quartTab[i]), "bias level");
        end
        $display("test decode done");

        // unmapped, misaligned and strobe-less accesses leave state alone
        wrReg(6'h02, 16'h0012);
        xfer(6'h01, 2'b00, 1'b1, 16'hFFFF, 4'hF);
        chk(32'(err), 32'h1, "unmapped write error");
        xfer(6'h06, 2'b00, 1'b0, 16'h0000, 4'h0);
        chk(rdat, 32'h0, "unmapped read");
        xfer(6'h02, 2'b10, 1'b1, 16'h0000, 4'hF);
        chk(32'(err), 32'h1, "misaligned error");
        xfer(6'h02, 2'b00, 1'b1, 16'h00FF, 4'h0);
        rdReg(6'h02, 16'h0012);
        xfer(6'h02, 2'b00, 1'b1, 16'hFF2A, 4'h2);
        rdReg(6'h02, 16'h0012);
        xfer(6'h02, 2'b00, 1'b1, 16'hFF2A, 4'h1);
        rdReg(6'h02, 16'h002A);
        $display("test refusals done");

        // soft reset through a strobe-less write with pending zero-cross volume
        wrReg(6'h05, 16'h0013);
        wrReg(6'h03, 16'h0041);
        xfer(6'h00, 2'b00, 1'b1, 16'h1234, 4'h0);
        tick(1);
        chk(32'(spkVolume), 32'h39, "applied volume default");
        chk(32'(midRef), 32'h01, "mid reference default");
        chk(32'(bias), 32'h68, "bias default");
        // applied bias level trails the register by one cycle
        tick(1);
        chk(32'(biasQuarters), 32'h4, "bias quarters default");
        rdReg(6'h00, FAM_ID);
        rdReg(6'h02, 16'h00B9);
        rdReg(6'h03, 16'h00B9);
        $display("test soft reset done");
        conclude();
    end
endmodule
